// [design/line_sync_pkg.sv]
package line_sync_pkg;
  // Register offsets on the control port
  localparam logic [7:0] ADDR_PHASE    = 8'h04;
  localparam logic [7:0] ADDR_WIDTH    = 8'h07;
  localparam logic [7:0] ADDR_POLARITY = 8'h10;
  localparam logic [7:0] ADDR_HOLDOVER = 8'h11;
  // Reset values
  localparam logic [7:0] RST_PHASE     = 8'h00;
  localparam logic [7:0] RST_WIDTH     = 8'h20;
  localparam logic [7:0] RST_POLARITY  = 8'h00;
  localparam logic [7:0] RST_HOLDOVER  = 8'h00;
  // Field positions
  localparam int PHASE_LSB             = 3;
  localparam int POL_DETECTED_BIT      = 0;
  localparam int POL_OUT_LOW_BIT       = 5;
  localparam int POL_IN_HIGH_BIT       = 6;
  localparam int POL_MANUAL_BIT        = 7;
  localparam int HOLD_LSB              = 1;
  localparam int HOLD_MSB              = 3;
  // Pixel clock geometry: one pixel is 32 phase steps of sys_clk
  localparam int PHASE_STEPS           = 32;
  localparam int PHASE_W               = 5;
  localparam logic [4:0] HALF_PERIOD   = 5'h10;
  // Line period tracking
  localparam int GAP_W                 = 16;
  localparam logic [15:0] GAP_MAX      = 16'hFFFF;
  localparam int TOL_SHIFT             = 2;
  // Polarity detector
  localparam logic [7:0] POL_CNT_INIT  = 8'h80;
  localparam logic [7:0] POL_CNT_MAX   = 8'hFF;
  localparam logic [7:0] POL_CNT_MIN   = 8'h00;
endpackage : line_sync_pkg

// [design/sync_polarity_detect.sv]
`timescale 1ns/1ps
module sync_polarity_detect
  import line_sync_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic hsync_pin,
  input  wire logic manual,
  input  wire logic manual_high,
  output logic      sync_norm,
  output logic      detected_low
);
  logic       meta;
  logic       synced;
  logic [7:0] pol_cnt;
  logic [7:0] next_pol_cnt;
  logic       next_sync_norm;
  logic       active_low;
  logic       settled;
  logic       next_settled;

  // Two flops before anything looks at the pin
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta   <= 1'b0;
      synced <= 1'b0;
    end else begin
      meta   <= hsync_pin;
      synced <= meta;
    end
  end

  // Sync pulses are short, so the level seen most of the time is the idle level
  always_comb begin
    next_pol_cnt = pol_cnt;
    if (synced && pol_cnt != POL_CNT_MAX) begin
      next_pol_cnt = pol_cnt + 8'h01;
    end else if (!synced && pol_cnt != POL_CNT_MIN) begin
      next_pol_cnt = pol_cnt - 8'h01;
    end
    active_low     = manual ? !manual_high : pol_cnt[7];
    // Idle level is unknown until the counter saturates once; holding the output
    // inactive until then keeps start-up from faking a leading edge
    next_settled   = settled || manual || pol_cnt == POL_CNT_MAX || pol_cnt == POL_CNT_MIN;
    next_sync_norm = settled && (synced ^ active_low);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pol_cnt      <= POL_CNT_INIT;
      settled      <= 1'b0;
      sync_norm    <= 1'b0;
      detected_low <= 1'b1;
    end else begin
      pol_cnt      <= next_pol_cnt;
      settled      <= next_settled;
      sync_norm    <= next_sync_norm;
      detected_low <= pol_cnt[7];
    end
  end
endmodule : sync_polarity_detect

// [design/hsync_output_coast_ctrl.sv]
// Behaviour
// - Data clock rises halfway between pixel data transitions.
// - Incoming line sync leading edge restarts the pixel clock generator.
// - Sampling phase steps through a full pixel in 32 equal steps.
// - Input sync polarity is detected; output polarity chosen by a bit.
// - Line sync output changes only with the pixel data, on data clock, or when the output polarity bit is written.
// - Line sync output lasts the programmed number of pixel clocks.
// - Holdover is generated internally from line sync timing.
// - During holdover, sync is blocked from generator; clock free-runs.
// - Each step is 1/32 pixel; line sync output shifts equally.
`timescale 1ns/1ps
module hsync_output_coast_ctrl
  import line_sync_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       hsync_in,
  input  wire logic [7:0] pixel_data_in,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  output logic      [7:0] reg_rdata,
  output logic      [7:0] pixel_data_out,
  output logic            pixel_data_clock_out,
  output logic            line_sync_out,
  output logic            pll_ref_out,
  output logic            holdover_active
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]         sampling_phase_adjust;
  logic [7:0]         line_sync_out_width;
  logic [7:0]         sync_polarity_control;
  logic [7:0]         holdover_control;
  logic [7:0]         next_rdata;
  logic               sync_norm;
  logic               detected_low;
  logic               sync_d;
  logic [7:0]         data_meta;
  logic [7:0]         data_sync;
  logic [PHASE_W-1:0] sub_cnt;
  logic [PHASE_W-1:0] phase;
  logic [GAP_W-1:0]   gap_cnt;
  logic [GAP_W-1:0]   ref_period;
  logic               edge_pending;
  logic [7:0]         width_cnt;
  logic               coast;
  logic [PHASE_W-1:0] next_sub_cnt;
  logic [GAP_W-1:0]   next_gap_cnt;
  logic [GAP_W-1:0]   next_ref_period;
  logic               next_edge_pending;
  logic [7:0]         next_width_cnt;
  logic               next_coast;
  logic [7:0]         next_data_out;
  logic               next_dclk;
  logic               next_line_sync;
  logic               next_pll_ref;
  logic               lead_edge;
  logic               good_edge;
  logic               pix_tick;
  logic               rise_tick;
  logic               coast_en;
  logic [GAP_W-1:0]   tol;

  ////////////////////////////////////////////////////////////////////////////
  // Register port; writes take effect at the next edge
  always_comb begin
    case (reg_addr)
      ADDR_PHASE:    next_rdata = sampling_phase_adjust;
      ADDR_WIDTH:    next_rdata = line_sync_out_width;
      ADDR_POLARITY: next_rdata = {sync_polarity_control[7:1], detected_low};
      ADDR_HOLDOVER: next_rdata = holdover_control;
      default:       next_rdata = 8'h00; // Unmapped reads as zero
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sampling_phase_adjust <= RST_PHASE;
      line_sync_out_width   <= RST_WIDTH;
      sync_polarity_control <= RST_POLARITY;
      holdover_control      <= RST_HOLDOVER;
      reg_rdata             <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
      if (reg_we && reg_addr == ADDR_PHASE)    sampling_phase_adjust <= reg_wdata;
      if (reg_we && reg_addr == ADDR_WIDTH)    line_sync_out_width   <= reg_wdata;
      if (reg_we && reg_addr == ADDR_POLARITY) sync_polarity_control <= reg_wdata;
      if (reg_we && reg_addr == ADDR_HOLDOVER) holdover_control      <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input sync normalised to active high
  sync_polarity_detect u_pol (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .hsync_pin    (hsync_in),
    .manual       (sync_polarity_control[POL_MANUAL_BIT]),
    .manual_high  (sync_polarity_control[POL_IN_HIGH_BIT]),
    .sync_norm    (sync_norm),
    .detected_low (detected_low)
  );

  // Pixel data pins pass two flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      data_meta <= 8'h00;
      data_sync <= 8'h00;
      sync_d    <= 1'b0;
    end else begin
      data_meta <= pixel_data_in;
      data_sync <= data_meta;
      sync_d    <= sync_norm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock generation, holdover and line sync output
  always_comb begin
    phase     = sampling_phase_adjust[PHASE_LSB +: PHASE_W];
    coast_en  = holdover_control[HOLD_MSB:HOLD_LSB] != 3'h0;
    lead_edge = sync_norm && !sync_d;
    tol       = ref_period >> TOL_SHIFT;
    // An edge far too early is an equalization pulse; when enabled it sets holdover instead of restarting
    good_edge = lead_edge && (!coast_en || ref_period == '0 ||
                              gap_cnt >= ref_period - tol);
    pix_tick  = sub_cnt == phase;
    rise_tick = sub_cnt == phase + HALF_PERIOD;

    next_gap_cnt    = (gap_cnt == GAP_MAX) ? gap_cnt : gap_cnt + 16'h0001;
    next_ref_period = ref_period;
    next_coast      = coast;
    if (good_edge) begin
      next_gap_cnt    = '0;
      next_ref_period = gap_cnt;
      next_coast      = 1'b0;
    end else if (coast_en && lead_edge) begin
      next_coast = 1'b1;
    end else if (coast_en && ref_period != '0 &&
                 {1'b0, gap_cnt} > {1'b0, ref_period} + {1'b0, tol}) begin
      // One extra bit so a long line period plus tolerance cannot wrap
      next_coast = 1'b1; // missing sync
    end
    if (!coast_en) begin
      next_coast = 1'b0;
    end

    // Reference edge restarts the phase counter; holdover lets it free-run
    if (good_edge && !coast) begin
      next_sub_cnt = '0;
    end else begin
      next_sub_cnt = sub_cnt + 5'h01;
    end
    next_pll_ref = sync_norm && !coast;

    // Set wins over the clear done at the pixel tick
    next_edge_pending = edge_pending;
    next_width_cnt    = width_cnt;
    next_data_out     = pixel_data_out;
    if (pix_tick) begin
      next_data_out     = data_sync;
      next_edge_pending = 1'b0;
      if (edge_pending) begin
        next_width_cnt = line_sync_out_width;
      end else if (width_cnt != 8'h00) begin
        next_width_cnt = width_cnt - 8'h01;
      end
    end
    if (good_edge) begin
      next_edge_pending = 1'b1;
    end
    next_line_sync = (next_width_cnt != 8'h00) ^
                     sync_polarity_control[POL_OUT_LOW_BIT];

    next_dclk = pixel_data_clock_out;
    if (rise_tick) begin
      next_dclk = 1'b1;
    end else if (pix_tick) begin
      next_dclk = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sub_cnt              <= '0;
      gap_cnt              <= '0;
      ref_period           <= '0;
      coast                <= 1'b0;
      edge_pending         <= 1'b0;
      width_cnt            <= 8'h00;
      pixel_data_out       <= 8'h00;
      pixel_data_clock_out <= 1'b0;
      line_sync_out        <= 1'b0;
      pll_ref_out          <= 1'b0;
      holdover_active      <= 1'b0;
    end else begin
      sub_cnt              <= next_sub_cnt;
      gap_cnt              <= next_gap_cnt;
      ref_period           <= next_ref_period;
      coast                <= next_coast;
      edge_pending         <= next_edge_pending;
      width_cnt            <= next_width_cnt;
      pixel_data_out       <= next_data_out;
      pixel_data_clock_out <= next_dclk;
      line_sync_out        <= next_line_sync;
      pll_ref_out          <= next_pll_ref;
      holdover_active      <= next_coast;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_dclk_rise;
    @(posedge sys_clk) disable iff (rst)
      rise_tick |=> pixel_data_clock_out && $stable(pixel_data_out);
  endproperty
  a_dclk_rise: assert property (p_dclk_rise) else $error("clock rise not mid data");

  property p_ref_restart;
    @(posedge sys_clk) disable iff (rst)
      (good_edge && !coast) |=> sub_cnt == 5'h00;
  endproperty
  a_ref_restart: assert property (p_ref_restart) else $error("no restart on sync");

  property p_phase_tick;
    @(posedge sys_clk) disable iff (rst)
      $changed(pixel_data_out) |-> $past(sub_cnt) == $past(phase);
  endproperty
  a_phase_tick: assert property (p_phase_tick) else $error("data off phase");

  property p_out_pol;
    @(posedge sys_clk) disable iff (rst)
      width_cnt == 8'h00 && $past(width_cnt) == 8'h00 |->
        line_sync_out == $past(sync_polarity_control[POL_OUT_LOW_BIT]);
  endproperty
  a_out_pol: assert property (p_out_pol) else $error("idle level wrong");

  property p_sync_align;
    @(posedge sys_clk) disable iff (rst)
      $changed(line_sync_out) && $stable(sync_polarity_control) |->
        $fell(pixel_data_clock_out) || $past(sub_cnt) == $past(phase);
  endproperty
  a_sync_align: assert property (p_sync_align) else $error("sync not on tick");

  property p_width_load;
    @(posedge sys_clk) disable iff (rst)
      (pix_tick && edge_pending) |=> width_cnt == $past(line_sync_out_width);
  endproperty
  a_width_load: assert property (p_width_load) else $error("width not loaded");

  property p_coast_early;
    @(posedge sys_clk) disable iff (rst)
      (lead_edge && !good_edge && coast_en) |=> ##1 holdover_active;
  endproperty
  a_coast_early: assert property (p_coast_early) else $error("holdover missed");

  property p_coast_block;
    @(posedge sys_clk) disable iff (rst)
      coast |=> !pll_ref_out;
  endproperty
  a_coast_block: assert property (p_coast_block) else $error("ref not blocked");

  property p_free_run;
    @(posedge sys_clk) disable iff (rst)
      coast |=> sub_cnt == $past(sub_cnt) + 5'h01;
  endproperty
  a_free_run: assert property (p_free_run) else $error("clock not free running");

  c_pulse: cover property (@(posedge sys_clk) disable iff (rst)
    $rose(width_cnt != 8'h00) ##[1:300] width_cnt == 8'h00);
  c_coast: cover property (@(posedge sys_clk) disable iff (rst) $rose(holdover_active));
  c_recover: cover property (@(posedge sys_clk) disable iff (rst) $fell(holdover_active));
endmodule : hsync_output_coast_ctrl

// [verif/pixel_sink_model.sv]
`timescale 1ns/1ps
module pixel_sink_model (
  input  wire logic       sys_clk,
  input  wire logic       watch,
  input  wire logic [7:0] pixel_data_out,
  input  wire logic       pixel_data_clock_out,
  input  wire logic       line_sync_out,
  output int              faults,
  output int              pixels
);
  logic [7:0] d_q;
  logic       c_q;
  logic       s_q;
  initial begin
    faults = 0;
    pixels = 0;
  end
  // Latch on the rising data clock; data that moves on that edge is a fault
  always @(posedge sys_clk) begin
    if (pixel_data_clock_out && !c_q) begin
      pixels <= pixels + 1;
      if (pixel_data_out !== d_q) faults <= faults + 1;
    end
    // Sync may only move together with the data, and the clock is low then
    if (watch && line_sync_out !== s_q &&
        (pixel_data_out === d_q || pixel_data_clock_out !== 1'b0)) begin
      faults <= faults + 1;
    end
    d_q <= pixel_data_out;
    c_q <= pixel_data_clock_out;
    s_q <= line_sync_out;
  end
endmodule : pixel_sink_model

// [verif/hsync_output_coast_ctrl_tb.sv]
`timescale 1ns/1ps
module hsync_output_coast_ctrl_tb
  import line_sync_pkg::*;
;
  logic        sys_clk, rst, hsync_in, reg_we, pixel_data_clock_out;
  logic        line_sync_out, pll_ref_out, holdover_active;
  logic [7:0]  pixel_data_in, reg_addr, reg_wdata, reg_rdata, pixel_data_out;
  logic        hs_act, hs_inv, hs_q, out_low, act_q, pll_s, hold_s, watch;
  logic [15:0] since, lat, run, last_w, n_ls, l0;
  int          mismatches, checks_done, cyc, faults, pixels;
  wire         act = line_sync_out ^ out_low;
  logic [4:0]  ph [3] = '{5'h1F, 5'h05, 5'h10};

  hsync_output_coast_ctrl DUT (.sys_clk(sys_clk), .rst(rst), .hsync_in(hsync_in),
    .pixel_data_in(pixel_data_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_rdata(reg_rdata), .pixel_data_out(pixel_data_out),
    .pixel_data_clock_out(pixel_data_clock_out), .line_sync_out(line_sync_out),
    .pll_ref_out(pll_ref_out), .holdover_active(holdover_active));
  pixel_sink_model sink (.sys_clk(sys_clk), .watch(watch), .pixel_data_out(pixel_data_out),
    .pixel_data_clock_out(pixel_data_clock_out), .line_sync_out(line_sync_out),
    .faults(faults), .pixels(pixels));

  assign hsync_in = hs_act ^ hs_inv;
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Sample data changes every cycle so a stale output shows up
  always @(posedge sys_clk) pixel_data_in <= #1 pixel_data_in + 8'h01;
  // Pulse timing monitor: latency from pin edge, active length, pulse count
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      results();
    end
    hs_q <= hs_act;
    act_q <= act;
    since <= (hs_act && !hs_q) ? 16'h0000 : since + 16'h0001;
    if (act && !act_q) begin
      lat <= since;
      n_ls <= n_ls + 16'h0001;
    end
    run <= act ? run + 16'h0001 : 16'h0000;
    if (!act && act_q) last_w <= run;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 {reg_addr, reg_wdata, reg_we} = {a, d, 1'b1};
    @(posedge sys_clk);
    #1 reg_we = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    #1 reg_addr = a;
    @(posedge sys_clk);
    #1 check({8'h00, reg_rdata}, {8'h00, exp});
  endtask : rd
  // One line: 64-cycle pulse, then idle; holdover and reference sampled in pulse
  task automatic line(input int len);
    hs_act = 1'b1;
    repeat (10) @(posedge sys_clk);
    #1 {pll_s, hold_s} = {pll_ref_out, holdover_active};
    repeat (54) @(posedge sys_clk);
    #1 hs_act = 1'b0;
    repeat (len - 64) @(posedge sys_clk);
    #1;
  endtask : line
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(ADDR_PHASE, 8'h00);
    rd(ADDR_WIDTH, 8'h20);
    rd(ADDR_POLARITY, 8'h00);
    rd(ADDR_HOLDOVER, 8'h00);
    wr(ADDR_WIDTH, 8'hAA);
    wr(ADDR_PHASE, 8'hF8);
    rd(ADDR_WIDTH, 8'hAA);
    rd(ADDR_PHASE, 8'hF8);
    wr(8'h3C, 8'h55);
    rd(8'h3C, 8'h00);
    wr(ADDR_POLARITY, 8'h01); // Detected bit is read-only
    rd(ADDR_POLARITY, 8'h00);
  endtask : t_regs
  task automatic t_width();
    wr(ADDR_PHASE, 8'h00);
    wr(ADDR_WIDTH, 8'h03);
    wr(ADDR_POLARITY, 8'hC0);
    repeat (3) line(640);
    check(last_w, 16'd96);
    check(16'(pll_s), 16'h1);
    // Data word launched at a falling clock is the input from three cycles back
    @(negedge pixel_data_clock_out);
    @(posedge sys_clk);
    check({8'h00, pixel_data_out}, {8'h00, pixel_data_in - 8'h03});
    #1;
  endtask : t_width
  task automatic t_phase();
    repeat (2) line(640);
    l0 = lat;
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_PHASE, {ph[i], 3'b000});
      repeat (2) line(640);
      check(lat - l0, 16'(ph[i]));
      check(last_w, 16'd96);
    end
    wr(ADDR_PHASE, 8'h00);
  endtask : t_phase
  task automatic t_hold();
    for (int en = 0; en < 2; en++) begin
      wr(ADDR_HOLDOVER, en ? 8'h02 : 8'h00);
      repeat (4) line(640);
      line(200);
      line(440);
      check(16'(hold_s), 16'(en));
      check(16'(pll_s), 16'(1 - en));
      repeat (2) line(640);
      check(16'(hold_s), 16'h0);
    end
    // Missing sync: no edge well past the tolerance window sets holdover
    line(640);
    repeat (900) @(posedge sys_clk);
    #1 check(16'(holdover_active), 16'h1);
    wr(ADDR_HOLDOVER, 8'h00);
  endtask : t_hold
  task automatic t_zero();
    wr(ADDR_WIDTH, 8'h00);
    l0 = n_ls;
    repeat (2) line(640);
    check(n_ls, l0);
    wr(ADDR_WIDTH, 8'h03);
  endtask : t_zero
  task automatic t_pol();
    watch = 1'b0;
    wr(ADDR_POLARITY, 8'hE0);
    out_low = 1'b1;
    line(640);
    watch = 1'b1;
    line(640);
    check(16'(line_sync_out), 16'h1);
    check(last_w, 16'd96);
    watch = 1'b0;
    wr(ADDR_POLARITY, 8'h20);
    hs_inv = 1'b1;
    repeat (3) line(640);
    rd(ADDR_POLARITY, 8'h21);
    check(last_w, 16'd96);
  endtask : t_pol
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  initial begin
    {rst, reg_we, reg_addr, reg_wdata, pixel_data_in} = {1'b1, 1'b0, 24'h000000};
    {hs_act, hs_inv, hs_q, out_low, act_q, pll_s, hold_s, watch} = 8'h01;
    {since, lat, run, last_w, n_ls, l0} = '0;
    {mismatches, checks_done, cyc} = '0;
    repeat (8) @(posedge sys_clk);
    #1 rst = 1'b0;
    t_regs();
    t_width();
    t_phase();
    t_hold();
    t_zero();
    t_pol();
    check(16'(faults), 16'h0);
    check(16'(pixels > 0), 16'h1);
    results();
  end
endmodule : hsync_output_coast_ctrl_tb
